// ---- axil_slave.sv ----
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module axil_slave (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [`RADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`RADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrEn,
  output logic [`RADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [`RADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHave_r;
  logic wHave_r;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data may arrive in either order; both are held until paired
  assign awready = ce && !awHave_r && !bvalid;
  assign wready = ce && !wHave_r && !bvalid;
  assign wrEn = ce && awHave_r && wHave_r && !bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHave_r <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_r <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrEn) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrErr ? `RESP_ERR : `RESP_OK;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign arready = ce && !rvalid;
  assign rdAddr = araddr;

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OK;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdErr ? `RESP_ERR : `RESP_OK;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- instr_decode.sv ----
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module instr_decode (
  input wire logic [15:0] opcode,
  output tsx_pkg::op_e opKind,
  output logic [1:0] ptrMode,
  output logic bankSel,
  output logic [7:0] fField,
  output logic [7:0] literal
);
  import tsx_pkg::*;

  assign ptrMode = opcode[1:0];
  assign bankSel = opcode[8];
  assign fField = opcode[7:0];
  assign literal = opcode[7:0];

  always_comb begin
    opKind = OP_NONE;
    if (opcode[15:2] == `OPC_TBL_RD) begin
      opKind = OP_TBL_RD;
    end else if (opcode[15:2] == `OPC_TBL_WT) begin
      opKind = OP_TBL_WT;
    end else if (opcode[15:9] == `OPC_TST) begin
      opKind = OP_TST;
    end else if (opcode[15:8] == `OPC_XOR) begin
      opKind = OP_XOR;
    end
  end
endmodule

// ---- prog_mem_model.sv ----
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module prog_mem_model (
  input wire logic clk,
  input wire logic [`PTR_W-1:0] pmAddr,
  input wire logic pmRdEn,
  output logic [7:0] pmRdData,
  input wire logic [`DADDR_W-1:0] dataAddr,
  input wire logic dataRdEn,
  output logic [7:0] dataRdData
);
  logic [1:0] pmHold = 2'h0;
  logic [1:0] dHold = 2'h0;
  logic [`PTR_W-1:0] pmA = '0;
  logic [`DADDR_W-1:0] dA = '0;
  logic [7:0] pmByte;
  assign pmByte = pmA[0] ? ~pmA[8:1] ^ pmA[16:9] : pmA[8:1];
  // Outside the hold window the lines flip, so a late sample shows up
  assign pmRdData = (pmHold != 2'h0) ? pmByte : ~pmByte;
  assign dataRdData = (dHold != 2'h0) ? dA[7:0] : ~dA[7:0];
  always @(posedge clk) begin
    pmHold <= pmRdEn ? 2'h2 : (pmHold != 2'h0) ? pmHold - 2'h1 : 2'h0;
    dHold <= dataRdEn ? 2'h2 : (dHold != 2'h0) ? dHold - 2'h1 : 2'h0;
    if (pmRdEn) pmA <= pmAddr;
    if (dataRdEn) dA <= dataAddr;
  end
endmodule

// ---- table_access_skip_xor_exec.sv ----
// Function
// - Table read loads program byte at pointer into latch; mode picks pointer update.
// - Table pointer is 21 bits, byte addressed, 2-Mbyte range.
// - Pointer bit 0 picks low byte when clear, high byte when set.
// - Pre-increment moves pointer before access; post modes move it after capture.
// - Table write copies latch to holding register at pointer, same four modes.
// - Table write: two cycles; latch read in second phase, holding write in fourth.
// - Table ops and test-skip leave status flags untouched.
// - Test-skip on zero discards prefetched instruction, runs empty cycle; two cycles.
// - Skip over a two-word instruction takes three cycles, both empty.
// - Bank bit 0 uses access bank; 1 uses bank select register.
// - Bank bit 0, extended set on, field up to 95: indexed offset addressing.
// - Xor-literal folds 8-bit literal into accumulator in one cycle.
// - Xor-literal updates negative and zero flags only.
// - Extended set features stay off unless the enable bit is set.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module table_access_skip_xor_exec (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [`RADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`RADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [`PTR_W-1:0] pmAddr,
  output logic pmRdEn,
  input wire logic [7:0] pmRdData,
  output logic hrWrEn,
  output logic [`PTR_W-1:0] hrAddr,
  output logic [7:0] hrData,
  output logic dataRdEn,
  output logic [`DADDR_W-1:0] dataAddr,
  input wire logic [7:0] dataRdData,
  input wire logic [`DADDR_W-1:0] fsr2Value,
  output logic skipPulse,
  output logic noOpCycle,
  output logic busy
);
  import tsx_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic regHit(input logic [`RADDR_W-1:0] a);
    case (a)
      `RA_CTRL, `RA_INSTR, `RA_PTR, `RA_LATCH, `RA_ACC, `RA_STAT, `RA_BANK: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  endfunction

  function automatic logic [`PTR_W-1:0] stepPtr(input logic [`PTR_W-1:0] p,
                                                input logic [1:0] m);
    case (m)
      `MODE_POSTINC, `MODE_PREINC: stepPtr = p + `PTR_W'(1);
      `MODE_POSTDEC: stepPtr = p - `PTR_W'(1);
      default: stepPtr = p;
    endcase
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wrEn;
  logic [`RADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [`RADDR_W-1:0] rdAddr;
  logic [31:0] rdWord;

  axil_slave u_bus (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(!regHit(wrAddr)),
    .rdAddr(rdAddr),
    .rdData(rdWord),
    .rdErr(!regHit(rdAddr))
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  seq_e seq_r;
  logic [15:0] opcode_r;
  logic nextTwo_r;
  logic [1:0] qPhase_r;
  logic [1:0] cyc_r;
  logic [1:0] lastCyc;
  logic [1:0] cycUsed_r;
  logic skip_r;
  logic illegal_r;
  logic [`PTR_W-1:0] ptr_r;
  logic [7:0] latch_r;
  logic [7:0] acc_r;
  logic [7:0] xorRes;
  logic flagN_r;
  logic flagZ_r;
  logic [`BANK_W-1:0] bank_r;
  logic extEn_r;
  logic [31:0] ptrMerged;
  op_e opKind;
  logic [1:0] ptrMode;
  logic bankSel;
  logic [7:0] fField;
  logic [7:0] literal;

  instr_decode u_dec (
    .opcode(opcode_r),
    .opKind(opKind),
    .ptrMode(ptrMode),
    .bankSel(bankSel),
    .fField(fField),
    .literal(literal)
  );

  // Software may only touch state while nothing executes
  logic swWr;
  logic issue;
  logic run;
  logic tblOp;
  assign swWr = wrEn && (seq_r == SEQ_IDLE);
  assign issue = swWr && (wrAddr == `RA_INSTR);
  assign run = ce && (seq_r == SEQ_RUN);
  assign tblOp = (opKind == OP_TBL_RD) || (opKind == OP_TBL_WT);
  assign ptrMerged = applyStrobe({11'h000, ptr_r}, wrData, wrStrb);
  assign xorRes = acc_r ^ literal;

  function automatic logic at(input logic r, input logic [1:0] c, input logic [1:0] cy,
                              input logic [1:0] q, input logic [1:0] p);
    at = r && (c == cy) && (q == p);
  endfunction

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_comb begin
    case (opKind)
      OP_TBL_RD, OP_TBL_WT: lastCyc = `CYC_SECOND;
      OP_TST: lastCyc = skip_r ? (nextTwo_r ? `CYC_THIRD : `CYC_SECOND) : `CYC_FIRST;
      default: lastCyc = `CYC_FIRST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq_r <= SEQ_IDLE;
      opcode_r <= 16'h0000;
      nextTwo_r <= 1'b0;
      qPhase_r <= `PH_DECODE;
      cyc_r <= `CYC_FIRST;
      cycUsed_r <= `CYC_FIRST;
    end else if (ce) begin
      if (issue) begin
        seq_r <= SEQ_RUN;
        opcode_r <= wrData[15:0];
        nextTwo_r <= wrData[`INSTR_TWO];
        qPhase_r <= `PH_DECODE;
        cyc_r <= `CYC_FIRST;
      end else if (seq_r == SEQ_RUN) begin
        qPhase_r <= qPhase_r + `PH_STEP;
        if (qPhase_r == `PH_WRITE) begin
          if (cyc_r == lastCyc) begin
            seq_r <= SEQ_IDLE;
            cycUsed_r <= cyc_r + `PH_STEP;
          end else begin
            cyc_r <= cyc_r + `PH_STEP;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      illegal_r <= 1'b0;
    end else if (at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_DECODE)) begin
      illegal_r <= (opKind == OP_NONE);
    end
  end

  // ----------------------------------------
  // Table pointer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_r <= `RST_PTR;
    end else if (ce) begin
      if (swWr && wrAddr == `RA_PTR) begin
        ptr_r <= ptrMerged[`PTR_W-1:0];
      end else if (tblOp && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_WRITE)) begin
        if (ptrMode == `MODE_PREINC) begin
          ptr_r <= stepPtr(ptr_r, ptrMode);
        end
      end else if (tblOp && at(run, cyc_r, `CYC_SECOND, qPhase_r, `PH_WRITE)) begin
        if (ptrMode != `MODE_PREINC) begin
          ptr_r <= stepPtr(ptr_r, ptrMode);
        end
      end
    end
  end

  // bit 0 reaches memory as byte select
  assign pmAddr = ptr_r;

  // ----------------------------------------
  // Program memory read and table latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pmRdEn <= 1'b0;
      latch_r <= `RST_BYTE;
    end else if (ce) begin
      pmRdEn <= (opKind == OP_TBL_RD) && at(run, cyc_r, `CYC_SECOND, qPhase_r, `PH_DECODE);
      if (swWr && wrAddr == `RA_LATCH && wrStrb[0]) begin
        latch_r <= wrData[7:0];
      end else if ((opKind == OP_TBL_RD) && at(run, cyc_r, `CYC_SECOND, qPhase_r, `PH_WRITE)) begin
        latch_r <= pmRdData;
      end
    end
  end

  // ----------------------------------------
  // Holding register write
  // ----------------------------------------
  // Only the holding register is loaded; no erase or program is started here
  always_ff @(posedge clk) begin
    if (srst) begin
      hrWrEn <= 1'b0;
      hrAddr <= `RST_PTR;
      hrData <= `RST_BYTE;
    end else if (ce) begin
      if ((opKind == OP_TBL_WT) && at(run, cyc_r, `CYC_SECOND, qPhase_r, `PH_READ)) begin
        hrData <= latch_r;
        hrAddr <= ptr_r;
      end
      hrWrEn <= (opKind == OP_TBL_WT) && at(run, cyc_r, `CYC_SECOND, qPhase_r, `PH_PROC);
    end
  end

  // ----------------------------------------
  // Test register and skip
  // ----------------------------------------
  logic [`DADDR_W-1:0] tstAddr;
  always_comb begin
    if (bankSel) begin
      tstAddr = {bank_r, fField};
    end else if (extEn_r && fField <= `IDX_LIMIT) begin
      tstAddr = fsr2Value + {`ACC_LO_BANK, fField};
    end else begin
      tstAddr = {(fField >= `ACC_SPLIT) ? `ACC_HI_BANK : `ACC_LO_BANK, fField};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dataRdEn <= 1'b0;
      dataAddr <= '0;
      skip_r <= 1'b0;
      skipPulse <= 1'b0;
    end else if (ce) begin
      dataRdEn <= (opKind == OP_TST) && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_DECODE);
      if ((opKind == OP_TST) && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_DECODE)) begin
        dataAddr <= tstAddr;
      end
      if (issue) begin
        skip_r <= 1'b0;
      end else if ((opKind == OP_TST) && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_PROC)) begin
        skip_r <= (dataRdData == `RST_BYTE);
      end
      skipPulse <= (opKind == OP_TST) && skip_r &&
                   at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_WRITE);
    end
  end

  assign noOpCycle = (seq_r == SEQ_RUN) && (opKind == OP_TST) && (cyc_r != `CYC_FIRST);
  assign busy = (seq_r == SEQ_RUN);

  // ----------------------------------------
  // Accumulator and flags
  // ----------------------------------------
  // only the xor path and software status writes change flags
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r <= `RST_BYTE;
      flagN_r <= 1'b0;
      flagZ_r <= 1'b0;
    end else if (ce) begin
      if (swWr && wrAddr == `RA_ACC && wrStrb[0]) begin
        acc_r <= wrData[7:0];
      end else if ((opKind == OP_XOR) && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_WRITE)) begin
        acc_r <= xorRes;
      end
      if (swWr && wrAddr == `RA_STAT && wrStrb[0]) begin
        flagN_r <= wrData[`ST_N];
        flagZ_r <= wrData[`ST_Z];
      end else if ((opKind == OP_XOR) && at(run, cyc_r, `CYC_FIRST, qPhase_r, `PH_WRITE)) begin
        flagN_r <= xorRes[7];
        flagZ_r <= (xorRes == `RST_BYTE);
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      extEn_r <= 1'b0;
      bank_r <= '0;
    end else if (ce && swWr && wrStrb[0]) begin
      if (wrAddr == `RA_CTRL) begin
        extEn_r <= wrData[`CTRL_EXT];
      end
      if (wrAddr == `RA_BANK) begin
        bank_r <= wrData[`BANK_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_comb begin
    rdWord = 32'h00000000;
    case (rdAddr)
      `RA_CTRL: rdWord[`CTRL_EXT] = extEn_r;
      `RA_INSTR: rdWord = {15'h0000, nextTwo_r, opcode_r};
      `RA_PTR: rdWord[`PTR_W-1:0] = ptr_r;
      `RA_LATCH: rdWord[7:0] = latch_r;
      `RA_ACC: rdWord[7:0] = acc_r;
      `RA_STAT: begin
        rdWord[`ST_Z] = flagZ_r;
        rdWord[`ST_N] = flagN_r;
        rdWord[`ST_BUSY] = busy;
        rdWord[`ST_SKIP] = skip_r;
        rdWord[`ST_ILL] = illegal_r;
        rdWord[`ST_CYC +: 2] = cycUsed_r;
      end
      `RA_BANK: rdWord[`BANK_W-1:0] = bank_r;
      default: rdWord = 32'h00000000;
    endcase
  end
endmodule

// ---- table_access_skip_xor_exec_assertions.sv ----
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module tsx_exec_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic pmRdEn,
  input wire logic [`PTR_W-1:0] pmAddr,
  input wire logic hrWrEn,
  input wire logic [`PTR_W-1:0] hrAddr,
  input wire logic [7:0] hrData,
  input wire logic dataRdEn,
  input wire logic [7:0] dataRdData,
  input wire logic skipPulse,
  input wire logic noOpCycle
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_rd_slot;
    pmRdEn |-> $past(busy, 5) && !$past(busy, 6);
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("memory read off its slot");
  property p_rd_end;
    pmRdEn |-> ##2 busy ##1 !busy;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("table read length wrong");
  property p_wt_slot;
    hrWrEn |-> $past(busy, 7) && !$past(busy, 8) ##1 !busy;
  endproperty
  a_wt_slot: assert property (p_wt_slot) else $error("holding write off its slot");
  property p_wt_hold;
    hrWrEn |-> $stable(hrAddr) && $stable(hrData) && hrAddr == pmAddr;
  endproperty
  a_wt_hold: assert property (p_wt_hold) else $error("holding address wrong");
  property p_rd_ptr;
    pmRdEn |-> $stable(pmAddr);
  endproperty
  a_rd_ptr: assert property (p_rd_ptr) else $error("pointer moved during access");
  property p_skip_cause;
    skipPulse |-> $past(dataRdEn, 3) && $past(dataRdData, 2) == 8'h00;
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip without zero");
  property p_no_skip;
    dataRdEn ##1 dataRdData != 8'h00 |-> ##2 !skipPulse && !busy;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero operand skipped");
  property p_skip_len;
    skipPulse |-> (busy && noOpCycle) [*4] ##1 (busy == noOpCycle);
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip cycles wrong");
  property p_noop_src;
    $rose(noOpCycle) |-> skipPulse;
  endproperty
  a_noop_src: assert property (p_noop_src) else $error("empty cycle without skip");
endmodule
bind table_access_skip_xor_exec tsx_exec_checker u_chk (.clk, .srst, .busy, .pmRdEn, .pmAddr,
  .hrWrEn, .hrAddr, .hrData, .dataRdEn, .dataRdData, .skipPulse, .noOpCycle);

// ---- table_access_skip_xor_exec_tb_top.sv ----
`timescale 1ns/1ps
`include "tsx_cfg.svh"
module table_access_skip_xor_exec_tb_top;
  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [31:0] ins;
    int cyc;
    logic [7:0] ra;
    logic [31:0] msk;
    logic [31:0] ex;
    logic [11:0] da;
  } row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] fsr2Value = 12'h1F0;
  logic awready, wready, bvalid, arready, rvalid, pmRdEn, hrWrEn, dataRdEn;
  logic skipPulse, noOpCycle, busy;
  logic [1:0] bresp, rresp, lastB;
  logic [31:0] rdata;
  logic [20:0] pmAddr, hrAddr, hrA;
  logic [7:0] pmRdData, hrData, dataRdData, hrD;
  logic [11:0] dataAddr, lastDa;
  int bc, hrN, errTotal, nTests;
  row_s rows [13] = '{
    '{`RA_ACC, 32'h5A, 32'h0A0F, 4, `RA_ACC, 32'hFF, 32'h55, 12'h0},
    '{`RA_ACC, 32'h80, 32'h0A01, 4, `RA_STAT, 32'h3, 32'h2, 12'h0},
    '{`RA_ACC, 32'h5A, 32'h0A5A, 4, `RA_STAT, 32'h3, 32'h1, 12'h0},
    '{`RA_STAT, 32'h3, 32'h0009, 8, `RA_STAT, 32'h3, 32'h3, 12'h0},
    '{`RA_STAT, 32'h3, 32'h6605, 4, `RA_STAT, 32'h203, 32'h3, 12'h005},
    '{`RA_BANK, 32'h3, 32'h6700, 8, `RA_STAT, 32'h200, 32'h200, 12'h300},
    '{`RA_BANK, 32'h3, 32'h16600, 12, `RA_STAT, 32'h200, 32'h200, 12'h000},
    '{`RA_CTRL, 32'h0, 32'h6670, 4, `RA_STAT, 32'h200, 32'h0, 12'hF70},
    '{`RA_CTRL, 32'h1, 32'h6610, 8, `RA_STAT, 32'h200, 32'h200, 12'h200},
    '{`RA_CTRL, 32'h1, 32'h665F, 4, `RA_STAT, 32'h200, 32'h0, 12'h24F},
    '{`RA_CTRL, 32'h1, 32'h6660, 4, `RA_STAT, 32'h200, 32'h0, 12'hF60},
    '{`RA_CTRL, 32'h0, 32'h6610, 4, `RA_STAT, 32'h200, 32'h0, 12'h010},
    '{`RA_CTRL, 32'h0, 32'hFFFF, 4, `RA_STAT, 32'h400, 32'h400, 12'h0}};
  table_access_skip_xor_exec dut (.clk, .srst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .pmAddr, .pmRdEn, .pmRdData, .hrWrEn, .hrAddr, .hrData, .dataRdEn,
    .dataAddr, .dataRdData, .fsr2Value, .skipPulse, .noOpCycle, .busy);
  prog_mem_model mem (.clk, .pmAddr, .pmRdEn, .pmRdData, .dataAddr, .dataRdEn, .dataRdData);
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ------
  // Monitors
  // ------
  always @(posedge clk) begin
    if (busy) bc <= bc + 1;
    else if (awvalid) bc <= 0;
    if (dataRdEn) lastDa <= dataAddr;
    if (hrWrEn) begin
      hrA <= hrAddr;
      hrD <= hrData;
      hrN <= hrN + 1;
    end
  end
  function automatic logic [7:0] pmv(input logic [20:0] a);
    return a[0] ? ~a[8:1] ^ a[16:9] : a[8:1];
  endfunction
  task automatic chkV(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkN(input int g, input int e);
    nTests++;
    if (g != e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t count %0d exp %0d", $time, g, e);
    end
  endtask
  // ------
  // Bus cycles
  // ------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awready === 1'b1;
      tw = tw || wready === 1'b1;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    lastB = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // Busy clocks are counted by the monitor from the issuing write on
  task automatic exec(input logic [31:0] ins, output int n);
    axw(`RA_INSTR, ins);
    do @(negedge clk); while (busy === 1'b1);
    n = bc;
  endtask
  task automatic wrapUp();
    if (errTotal == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #500000;
    errTotal++;
    wrapUp();
  end
  // ------
  // Main sequence
  // ------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [20:0] p, a, q;
    int n;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      axw(rows[i].wa, rows[i].wd);
      exec(rows[i].ins, n);
      chkN(n, rows[i].cyc);
      axr(`RA_STAT, d, r);
      chkV({30'h0, d[17:16]}, 32'(rows[i].cyc / 4));
      axr(rows[i].ra, d, r);
      chkV(d & rows[i].msk, rows[i].ex);
      if (rows[i].ins[15:9] == `OPC_TST) chkV({20'h0, lastDa}, {20'h0, rows[i].da});
    end
    for (int m = 0; m < 4; m++) begin
      p = (m == 3) ? 21'h1FFFFF : {20'h0ABCD, m[0]};
      a = (m == 3) ? p + 21'h1 : p;
      q = (m == 2) ? p - 21'h1 : (m == 0) ? p : p + 21'h1;
      axw(`RA_PTR, {11'h0, p});
      exec(32'(8 + m), n);
      chkN(n, 8);
      axr(`RA_LATCH, d, r);
      chkV(d, {24'h0, pmv(a)});
      axr(`RA_PTR, d, r);
      chkV(d, {11'h0, q});
      axw(`RA_LATCH, 32'(48 + m));
      axw(`RA_PTR, {11'h0, p});
      exec(32'(12 + m), n);
      chkN(n, 8);
      chkV({11'h0, hrA}, {11'h0, a});
      chkV({24'h0, hrD}, 32'(48 + m));
      axr(`RA_PTR, d, r);
      chkV(d, {11'h0, q});
    end
    chkN(hrN, 4);
    // Clock enable low freezes a running xor, so it stays busy five clocks longer
    axw(`RA_ACC, 32'h3C);
    axw(`RA_INSTR, 32'h0A0F);
    ce <= 1'b0;
    @(negedge clk);
    chkV({31'h0, awready}, 32'h0);
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    do @(negedge clk); while (busy === 1'b1);
    chkN(bc, 9);
    axr(`RA_ACC, d, r);
    chkV(d, 32'h33);
    // Second reset while idle, then reset values and an unmapped slot
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      axr(8'(k * 4), d, r);
      chkV(d, 32'h0);
    end
    axr(8'h1C, d, r);
    chkV({30'h0, r}, {30'h0, `RESP_ERR});
    axw(8'h1C, 32'h1);
    chkV({30'h0, lastB}, {30'h0, `RESP_ERR});
    wrapUp();
  end
endmodule

// ---- tsx_cfg.svh ----
`ifndef TSX_CFG_SVH
`define TSX_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define PTR_W 21
`define DADDR_W 12
`define BANK_W 4
`define RADDR_W 8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RA_CTRL 8'h00
`define RA_INSTR 8'h04
`define RA_PTR 8'h08
`define RA_LATCH 8'h0C
`define RA_ACC 8'h10
`define RA_STAT 8'h14
`define RA_BANK 8'h18

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_EXT 0
`define INSTR_TWO 16
`define ST_Z 0
`define ST_N 1
`define ST_BUSY 8
`define ST_SKIP 9
`define ST_ILL 10
`define ST_CYC 16
`define RST_BYTE 8'h00
`define RST_PTR 21'h000000

// ----------------------------------------
// Opcode patterns and addressing
// ----------------------------------------
`define OPC_TBL_RD 14'h0002
`define OPC_TBL_WT 14'h0003
`define OPC_TST 7'h33
`define OPC_XOR 8'h0A
`define IDX_LIMIT 8'h5F
`define ACC_SPLIT 8'h60
`define ACC_HI_BANK 4'hF
`define ACC_LO_BANK 4'h0
`define MODE_NONE 2'h0
`define MODE_POSTINC 2'h1
`define MODE_POSTDEC 2'h2
`define MODE_PREINC 2'h3

// ----------------------------------------
// Phases within one instruction cycle
// ----------------------------------------
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROC 2'h2
`define PH_WRITE 2'h3
`define PH_STEP 2'h1
`define CYC_FIRST 2'h0
`define CYC_SECOND 2'h1
`define CYC_THIRD 2'h2

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// ---- tsx_pkg.sv ----
package tsx_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_TBL_RD = 3'b001,
    OP_TBL_WT = 3'b010,
    OP_TST = 3'b011,
    OP_XOR = 3'b100
  } op_e;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_e;

  function automatic logic [31:0] applyStrobe(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage
